// File: inc/alert_throttle_pkg.sv
// Constants for the alert mask and throttle timer block.
// Assumes a 10 MHz core clock and an 8-bit register port from the serial engine.
package alert_throttle_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
  localparam logic [7:0] ADDR_MASK_ONE = 8'h74;
  localparam logic [7:0] ADDR_MASK_TWO = 8'h75;
  localparam logic [7:0] ADDR_CONFIG_THREE = 8'h78;
  localparam logic [7:0] ADDR_TIMER = 8'h79;
  localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h7A;
  localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h7D;

  // ----------------------------------------------------------------
  // Reset values and byte constants
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_MASK = 8'h00;
  localparam logic [7:0] RESET_LIMIT = 8'h00;
  localparam logic [2:0] RESET_CONFIG_THREE = 3'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] FULL_SCALE = 8'hFF;
  localparam logic [7:0] ONE_BYTE = 8'h01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG3_ALERT_ENABLE = 0;
  localparam int CFG3_THROTTLE_ENABLE = 1;
  localparam int CFG3_FULL_SPEED = 2;
  localparam int STAT1_SUMMARY = 7;
  localparam int STAT1_SUPPLY = 2;
  localparam int STAT1_PROCESSOR = 1;
  localparam int MASK1_SUPPLY = 2;
  localparam int MASK1_PROCESSOR = 0;
  localparam int STAT2_FAN_FOUR = 5;
  localparam logic [7:0] STAT1_SOURCES = 8'h76;
  localparam logic [7:0] STAT2_SOURCES = 8'hFE;
  localparam logic [7:0] STAT1_TEMPS = 8'h70;

  // ----------------------------------------------------------------
  // Pin 9 function select
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIN9_TACH = 2'h0,
    PIN9_THROTTLE = 2'h1,
    PIN9_ALERT = 2'h2,
    PIN9_GPIO = 2'h3
  } pin9_func_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMER_LSB_NS = 22760000;
  localparam int TIMER_LSB_CYCLES = TIMER_LSB_NS / CLK_PERIOD_NS;

endpackage

// File: hw/level_sync.sv
// Two-stage synchroniser for levels from outside the core clock domain.
// Assumes inputs are slow levels; no pulse shorter than two clocks matters.
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage_one;

  // ----------------------------------------------------------------
  // Two flops, first read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage_one <= INIT;
      o_sync <= INIT;
    end else begin
      stage_one <= i_async;
      o_sync <= stage_one;
    end
  end
endmodule
`default_nettype wire

// File: hw/throttle_timer.sv
// Cumulative, saturating, clear-on-read throttle assertion timer.
// Assumes i_active is already synchronised to the core clock.
`timescale 1ns/1ps
`default_nettype none
module throttle_timer #(
  parameter int LSB_CYCLES = alert_throttle_pkg::TIMER_LSB_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Control
  input wire logic i_active,
  input wire logic i_clear,
  // Value
  output logic [7:0] o_value
);
  import alert_throttle_pkg::*;

  logic [31:0] prescale;
  logic [7:0] units;
  logic seen;
  logic tick;

  assign tick = i_active && (prescale == 32'(LSB_CYCLES - 1));

  // ----------------------------------------------------------------
  // Accumulation
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prescale <= '0;
      units <= ZERO_BYTE;
      seen <= 1'b0;
    end else if (i_clear) begin
      prescale <= '0;
      units <= ZERO_BYTE;
      seen <= i_active;
    end else if (i_active) begin
      seen <= 1'b1;
      prescale <= tick ? '0 : prescale + 32'd1;
      if (tick && units != FULL_SCALE) begin
        units <= units + ONE_BYTE;
      end
    end
  end

  // Bit 0 marks first assertion until the first full step
  assign o_value = (seen && units == ZERO_BYTE) ? ONE_BYTE : units;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence first_assert;
    !i_active && o_value == ZERO_BYTE ##1 i_active && !i_clear;
  endsequence

  a_timer_first_bit: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    first_assert |=> o_value == ONE_BYTE)
    else $error("timer bit 0 not set on first assertion");

  a_timer_read_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_clear && !i_active |=> o_value == ZERO_BYTE)
    else $error("timer not cleared by read");

  a_timer_hold_idle: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !i_active && !i_clear |=> $stable(o_value))
    else $error("timer moved while throttle released");

  a_timer_saturate: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    o_value == FULL_SCALE && !i_clear |=> o_value == FULL_SCALE)
    else $error("timer left full scale without clear");
endmodule
`default_nettype wire

// File: hw/alert_mask_throttle.sv
// Alert masking, pin function select and throttle time monitoring.
// Assumes a register port from the serial engine with one-cycle strobes
// on the core clock; measurement status conditions arrive as levels.
`timescale 1ns/1ps
`default_nettype none
module alert_mask_throttle #(
  parameter int TIMER_LSB = alert_throttle_pkg::TIMER_LSB_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Out-of-limit conditions from the measurement channels
  input wire logic [7:0] i_cond_one,
  input wire logic [7:0] i_cond_two,
  // Fan state and override
  input wire logic [3:0] i_fan_running,
  output logic [3:0] o_fan_full_speed,
  // Pin 5, open-drain alert
  output logic o_pin5,
  output logic o_pin5_oe_n,
  // Pin 9, multi-purpose
  input wire logic i_pin9,
  output logic o_pin9,
  output logic o_pin9_oe_n,
  output logic o_fourth_fan_low_speed_tach,
  // GPIO on pin 9
  input wire logic i_gpio_level,
  input wire logic i_gpio_output,
  output logic o_gpio_sample
);
  import alert_throttle_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] alert_mask_one;
  logic [7:0] alert_mask_two;
  logic [7:0] throttle_time_limit;
  logic [2:0] config_three;
  pin9_func_t pin9_func;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [7:0] next_status_one;
  logic [7:0] next_status_two;
  logic [7:0] cond_two_eff;
  logic [7:0] status_one_view;
  logic [7:0] throttle_time_accumulator;
  logic pin9_sync;
  logic throttle_mode;
  logic throttle_active;
  logic timer_over;
  logic rd_status_one;
  logic rd_status_two;
  logic rd_timer;
  logic alert_cond;
  logic alert_pin5_en;
  logic alert_pin9_en;

  // Address match for a strobe
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
                               input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction

  // Unmasked pending bits for a status and mask pair
  function automatic logic pending(input logic [7:0] stat, input logic [7:0] mask);
    pending = |(stat & ~mask);
  endfunction

  assign rd_status_one = hit(i_reg_rd, i_reg_addr, ADDR_STATUS_ONE);
  assign rd_status_two = hit(i_reg_rd, i_reg_addr, ADDR_STATUS_TWO);
  assign rd_timer = hit(i_reg_rd, i_reg_addr, ADDR_TIMER);

  // ----------------------------------------------------------------
  // Pin 9 input synchroniser
  // ----------------------------------------------------------------
  level_sync #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_pin9_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async(i_pin9),
    .o_sync(pin9_sync)
  );

  // ----------------------------------------------------------------
  // Configuration and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      alert_mask_one <= RESET_MASK;
      alert_mask_two <= RESET_MASK;
    end else begin
      if (hit(i_reg_wr, i_reg_addr, ADDR_MASK_ONE)) begin
        alert_mask_one <= i_reg_wdata;
      end
      if (hit(i_reg_wr, i_reg_addr, ADDR_MASK_TWO)) begin
        alert_mask_two <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      config_three <= RESET_CONFIG_THREE;
      pin9_func <= PIN9_TACH;
    end else begin
      if (hit(i_reg_wr, i_reg_addr, ADDR_CONFIG_THREE)) begin
        config_three <= i_reg_wdata[2:0];
      end
      if (hit(i_reg_wr, i_reg_addr, ADDR_CONFIG_FOUR)) begin
        pin9_func <= pin9_func_t'(i_reg_wdata[1:0]);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      throttle_time_limit <= RESET_LIMIT;
    end else if (hit(i_reg_wr, i_reg_addr, ADDR_TIMER_LIMIT)) begin
      throttle_time_limit <= i_reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Throttle input and timer
  // ----------------------------------------------------------------
  assign throttle_mode = (pin9_func == PIN9_THROTTLE)
                         && config_three[CFG3_THROTTLE_ENABLE];
  assign throttle_active = throttle_mode && !pin9_sync;

  throttle_timer #(
    .LSB_CYCLES(TIMER_LSB)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_active(throttle_active),
    .i_clear(rd_timer),
    .o_value(throttle_time_accumulator)
  );

  assign timer_over = throttle_mode
                      && (throttle_time_accumulator > throttle_time_limit);

  // ----------------------------------------------------------------
  // Sticky status
  // ----------------------------------------------------------------
  always_comb begin
    cond_two_eff = i_cond_two & STAT2_SOURCES;
    if (pin9_func != PIN9_TACH) begin
      cond_two_eff[STAT2_FAN_FOUR] = timer_over;
    end
  end

  always_comb begin
    next_status_one = status_one | (i_cond_one & STAT1_SOURCES);
    if (rd_status_one) begin
      next_status_one = i_cond_one & STAT1_SOURCES;
    end
    next_status_two = status_two | cond_two_eff;
    if (rd_status_two) begin
      next_status_two = cond_two_eff;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_one <= ZERO_BYTE;
      status_two <= ZERO_BYTE;
    end else begin
      status_one <= next_status_one;
      status_two <= next_status_two;
    end
  end

  always_comb begin
    status_one_view = status_one;
    status_one_view[STAT1_SUMMARY] = |status_two;
  end

  // ----------------------------------------------------------------
  // Alert gating
  // ----------------------------------------------------------------
  always_comb begin
    alert_cond = pending(status_one & STAT1_TEMPS, alert_mask_one);
    if (status_one[STAT1_SUPPLY] && !alert_mask_one[MASK1_SUPPLY]) begin
      alert_cond = 1'b1;
    end
    if (status_one[STAT1_PROCESSOR] && !alert_mask_one[MASK1_PROCESSOR]) begin
      alert_cond = 1'b1;
    end
    if (pending(status_two, alert_mask_two) && !alert_mask_one[STAT1_SUMMARY]) begin
      alert_cond = 1'b1;
    end
  end

  assign alert_pin5_en = config_three[CFG3_ALERT_ENABLE];
  assign alert_pin9_en = (pin9_func == PIN9_ALERT);

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin5 <= 1'b1;
      o_pin5_oe_n <= 1'b1;
      o_pin9 <= 1'b1;
      o_pin9_oe_n <= 1'b1;
    end else begin
      o_pin5 <= 1'b0;
      o_pin5_oe_n <= !(alert_pin5_en && alert_cond);
      case (pin9_func)
        PIN9_ALERT: begin
          o_pin9 <= 1'b0;
          o_pin9_oe_n <= !alert_cond;
        end
        PIN9_GPIO: begin
          o_pin9 <= i_gpio_level;
          o_pin9_oe_n <= !i_gpio_output;
        end
        default: begin
          o_pin9 <= 1'b1;
          o_pin9_oe_n <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fourth_fan_low_speed_tach <= 1'b1;
      o_gpio_sample <= 1'b1;
      o_fan_full_speed <= 4'h0;
    end else begin
      o_fourth_fan_low_speed_tach <= (pin9_func == PIN9_TACH) ? pin9_sync : 1'b1;
      o_gpio_sample <= pin9_sync;
      o_fan_full_speed <= (config_three[CFG3_FULL_SPEED] && throttle_active)
                          ? i_fan_running : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= ZERO_BYTE;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          ADDR_STATUS_ONE: o_reg_rdata <= status_one_view;
          ADDR_STATUS_TWO: o_reg_rdata <= status_two;
          ADDR_MASK_ONE: o_reg_rdata <= alert_mask_one;
          ADDR_MASK_TWO: o_reg_rdata <= alert_mask_two;
          ADDR_CONFIG_THREE: o_reg_rdata <= {5'h00, config_three};
          ADDR_TIMER: o_reg_rdata <= throttle_time_accumulator;
          ADDR_TIMER_LIMIT: o_reg_rdata <= throttle_time_limit;
          ADDR_CONFIG_FOUR: o_reg_rdata <= {6'h00, pin9_func};
          default: o_reg_rdata <= ZERO_BYTE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence over_limit;
    timer_over && pin9_func == PIN9_THROTTLE;
  endsequence

  sequence status_read_two;
    rd_status_two && !cond_two_eff[STAT2_FAN_FOUR];
  endsequence

  a_mask_keeps_status: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_cond_two[2] && alert_mask_two[2] |=> status_two[2])
    else $error("masked source did not set status");

  a_summary_bit: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    rd_status_one |=> o_reg_rvalid && o_reg_rdata[STAT1_SUMMARY] == |$past(status_two))
    else $error("summary bit does not follow second status");

  a_alert_off_reset: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !config_three[CFG3_ALERT_ENABLE] |=> o_pin5_oe_n)
    else $error("pin 5 driven with alert disabled");

  a_alert_drives_low: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    alert_cond && alert_pin5_en |=> !o_pin5_oe_n && !o_pin5)
    else $error("alert not driven low");

  a_full_speed_on_throttle_running: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    config_three[CFG3_FULL_SPEED] && throttle_active |=> o_fan_full_speed == $past(i_fan_running))
    else $error("running fans not boosted");

  a_full_speed_on_throttle_idle_fans: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_fan_running == 4'h0 || !throttle_active |=> o_fan_full_speed == 4'h0)
    else $error("full_speed_on_throttle applied to stopped fans or without throttle");

  a_limit_status: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    over_limit |=> status_two[STAT2_FAN_FOUR])
    else $error("timer over limit did not set status");

  a_sticky_hold: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    status_two[STAT2_FAN_FOUR] && !rd_status_two |=> status_two[STAT2_FAN_FOUR])
    else $error("sticky status cleared without read");

  a_read_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    status_read_two ##1 !cond_two_eff[STAT2_FAN_FOUR] |-> !status_two[STAT2_FAN_FOUR])
    else $error("status not cleared by read after condition");

  a_throttle_mask: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    alert_pin9_en == 1'b0 && alert_pin5_en && status_one == ZERO_BYTE
    && status_two == 8'h20 && alert_mask_two[STAT2_FAN_FOUR] |=> o_pin5_oe_n)
    else $error("masked throttle event raised alert");
endmodule
`default_nettype wire

// File: tb/throttle_host_model.sv
// Far-side model: the open-drain pin 9 wire and whoever pulls it low.
// Assumes a pull-up on the wire and a free 800 ns link timebase.
`timescale 1ns/1ps
`default_nettype none
module throttle_host_model (
  // Design side of pin 9
  input wire logic i_pin9_drive,
  input wire logic i_pin9_oe_n,
  // Resolved wire
  output logic o_pin9_level
);
  logic link_clk;
  logic pull_low;

  initial begin
    link_clk = 1'b0;
    pull_low = 1'b0;
    #37;
    forever #400 link_clk = ~link_clk;
  end

  // Pull-up wins unless either party pulls low
  assign o_pin9_level = ~(pull_low | (~i_pin9_oe_n & ~i_pin9_drive));

  // Hold the line low for n link periods
  task automatic hold_low(input int n);
    @(posedge link_clk);
    pull_low = 1'b1;
    repeat (n) @(posedge link_clk);
    pull_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/alert_mask_throttle_tb.sv
// Self-checking bench for the alert mask and throttle timer block.
// Assumes the host model owns pin 9; reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e); end end
module alert_mask_throttle_tb;
  import alert_throttle_pkg::*;
  localparam int LSB = 16;
  logic i_core_clk, i_resetn, i_reg_wr, i_reg_rd, i_gpio_level, i_gpio_output;
  logic [7:0] i_reg_addr, i_reg_wdata, i_cond_one, i_cond_two, v;
  logic [3:0] i_fan_running, o_fan_full_speed;
  logic [7:0] o_reg_rdata;
  logic o_reg_rvalid, o_pin5, o_pin5_oe_n, o_pin9, o_pin9_oe_n, o_fourth_fan_low_speed_tach, o_gpio_sample;
  wire logic pin9_level;
  logic [7:0] exp_q[$];
  logic [7:0] exp_rd;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 9;
  int sbit[12] = '{6, 5, 4, 2, 1, 7, 6, 5, 4, 3, 2, 1};
  int mbit[12] = '{6, 5, 4, 2, 0, 7, 6, 5, 4, 3, 2, 1};

  alert_mask_throttle #(.TIMER_LSB(LSB)) u_alert_mask_throttle (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_cond_one(i_cond_one),
    .i_cond_two(i_cond_two), .i_fan_running(i_fan_running),
    .o_fan_full_speed(o_fan_full_speed), .o_pin5(o_pin5), .o_pin5_oe_n(o_pin5_oe_n),
    .i_pin9(pin9_level), .o_pin9(o_pin9), .o_pin9_oe_n(o_pin9_oe_n),
    .o_fourth_fan_low_speed_tach(o_fourth_fan_low_speed_tach), .i_gpio_level(i_gpio_level),
    .i_gpio_output(i_gpio_output), .o_gpio_sample(o_gpio_sample));

  throttle_host_model u_throttle_host_model (.i_pin9_drive(o_pin9),
    .i_pin9_oe_n(o_pin9_oe_n), .o_pin9_level(pin9_level));

  // ----------------------------------------------------------------
  // Clock, tasks and read checker
  // ----------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_core_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_core_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge i_core_clk);
    i_reg_rd = 1'b0;
  endtask

  always @(negedge i_core_clk) begin
    if (o_reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected read data")
      else begin
        exp_rd = exp_q.pop_front();
        `CHK(o_reg_rdata, exp_rd, "read data")
      end
    end
  end

  task automatic end_of_test();
    if (exp_q.size() != 0) `CHK(exp_q.size(), 0, "reads left unanswered")
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #5_000_000;
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_resetn, i_reg_wr, i_reg_rd, i_gpio_level, i_gpio_output} = '0;
    {i_reg_addr, i_reg_wdata, i_cond_one, i_cond_two} = '0;
    i_fan_running = 4'h0;
    repeat (8) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_resetn = 1'b1;
    rd(ADDR_MASK_ONE, RESET_MASK);
    rd(ADDR_MASK_TWO, RESET_MASK);
    rd(ADDR_TIMER_LIMIT, RESET_LIMIT);
    rd(8'h50, 8'h00);
    wr(ADDR_TIMER, 8'h5A);
    rd(ADDR_TIMER, 8'h00);
    v = 8'($random(seed));
    wr(ADDR_MASK_ONE, v);
    rd(ADDR_MASK_ONE, v);
    wr(ADDR_MASK_TWO, ~v);
    rd(ADDR_MASK_TWO, ~v);
    wr(ADDR_TIMER_LIMIT, v);
    rd(ADDR_TIMER_LIMIT, v);
    wr(ADDR_CONFIG_FOUR, 8'hFF);
    rd(ADDR_CONFIG_FOUR, 8'h03);
    wr(ADDR_CONFIG_FOUR, 8'h00);
    wr(ADDR_MASK_ONE, 8'h00);
    wr(ADDR_MASK_TWO, 8'h00);
    i_cond_one = 8'h40;
    tick(4);
    `CHK(o_pin5_oe_n, 1'b1, "alert before enable")
    wr(ADDR_CONFIG_THREE, 8'h01);
    for (int k = 0; k < 12; k++) begin
      if (k < 5) i_cond_one = 8'h01 << sbit[k];
      else i_cond_two = 8'h01 << sbit[k];
      tick(4);
      `CHK({o_pin5, o_pin5_oe_n}, 2'b00, "alert on source")
      if (k == 5) rd(ADDR_STATUS_ONE, 8'h80);
      wr(k < 5 ? ADDR_MASK_ONE : ADDR_MASK_TWO, 8'h01 << mbit[k]);
      tick(4);
      `CHK(o_pin5_oe_n, 1'b1, "masked source")
      i_cond_one = 8'h00;
      i_cond_two = 8'h00;
      tick(2);
      rd(k < 5 ? ADDR_STATUS_ONE : ADDR_STATUS_TWO, 8'h01 << sbit[k]);
      rd(k < 5 ? ADDR_STATUS_ONE : ADDR_STATUS_TWO, 8'h00);
      wr(k < 5 ? ADDR_MASK_ONE : ADDR_MASK_TWO, 8'h00);
    end
    // Random conditions on both status registers
    v = 8'($random(seed));
    i_cond_one = v;
    i_cond_two = ~v;
    tick(2);
    i_cond_one = 8'h00;
    i_cond_two = 8'h00;
    rd(ADDR_STATUS_TWO, ~v & STAT2_SOURCES);
    rd(ADDR_STATUS_ONE, v & STAT1_SOURCES);
    i_cond_two = 8'h04;
    wr(ADDR_MASK_ONE, 8'h80);
    tick(4);
    `CHK(o_pin5_oe_n, 1'b1, "summary masked")
    i_cond_two = 8'h00;
    rd(ADDR_STATUS_TWO, 8'h04);
    wr(ADDR_MASK_ONE, 8'h00);
    // Pin 9 functions
    wr(ADDR_CONFIG_THREE, 8'h00);
    wr(ADDR_CONFIG_FOUR, 8'h02);
    i_cond_one = 8'h20;
    tick(4);
    `CHK({o_pin9_oe_n, o_pin9, o_pin5_oe_n}, 3'b001, "pin 9 alert")
    i_cond_one = 8'h00;
    rd(ADDR_STATUS_ONE, 8'h20);
    tick(3);
    `CHK(o_pin9_oe_n, 1'b1, "pin 9 released")
    wr(ADDR_CONFIG_FOUR, 8'h00);
    fork
      u_throttle_host_model.hold_low(2);
      begin
        tick(12);
        `CHK(o_fourth_fan_low_speed_tach, 1'b0, "tach follows pin")
      end
    join
    wr(ADDR_CONFIG_FOUR, 8'h03);
    i_gpio_level = 1'($random(seed));
    fork
      u_throttle_host_model.hold_low(2);
      begin
        tick(12);
        `CHK(o_gpio_sample, 1'b0, "gpio sample")
      end
    join
    tick(1);
    i_gpio_output = 1'b1;
    tick(5);
    `CHK({o_pin9_oe_n, o_pin9, o_gpio_sample}, {1'b0, i_gpio_level, i_gpio_level}, "gpio drive")
    i_gpio_output = 1'b0;
    // Throttle timer
    wr(ADDR_CONFIG_FOUR, 8'h01);
    wr(ADDR_TIMER_LIMIT, 8'h01);
    wr(ADDR_CONFIG_THREE, 8'h01);
    u_throttle_host_model.hold_low(5);
    rd(ADDR_TIMER, 8'h00);
    wr(ADDR_CONFIG_THREE, 8'h07);
    i_fan_running = 4'($random(seed));
    fork
      u_throttle_host_model.hold_low(5);
      begin
        tick(20);
        `CHK(o_fan_full_speed, i_fan_running, "full speed")
      end
    join
    tick(4);
    `CHK({o_fan_full_speed, o_pin5_oe_n}, 5'h00, "after release")
    rd(ADDR_TIMER, 8'h02);
    rd(ADDR_STATUS_TWO, 8'h20);
    rd(ADDR_STATUS_TWO, 8'h00);
    u_throttle_host_model.hold_low(2);
    tick(10);
    u_throttle_host_model.hold_low(3);
    tick(4);
    rd(ADDR_TIMER, 8'h02);
    rd(ADDR_STATUS_TWO, 8'h20);
    u_throttle_host_model.hold_low(1);
    tick(4);
    rd(ADDR_TIMER, 8'h01);
    rd(ADDR_STATUS_TWO, 8'h00);
    wr(ADDR_MASK_TWO, 8'h20);
    wr(ADDR_TIMER_LIMIT, 8'h00);
    fork
      u_throttle_host_model.hold_low(520);
      begin
        tick(4100);
        `CHK(o_pin5_oe_n, 1'b1, "throttle alert masked")
        rd(ADDR_TIMER, 8'hFF);
        tick(3);
        rd(ADDR_TIMER, 8'h01);
        rd(ADDR_STATUS_TWO, 8'h20);
      end
    join
    wr(ADDR_MASK_TWO, 8'h00);
    tick(4);
    `CHK(o_pin5_oe_n, 1'b0, "throttle alert")
    tick(4);
    end_of_test();
  end
endmodule
`default_nettype wire
